//--- core/ccp_top.sv
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ccp_params.svh"
module ccp_top
(
    input  wire logic             CLK,
    input  wire logic             NRST,
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [7:0]       PADDR,
    input  wire logic [31:0]      PWDATA,
    output logic [31:0]           PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    input  wire ccp_pkg::ccp_byte_t MAIN_COUNT_HIGH,
    input  wire ccp_pkg::ccp_byte_t MAIN_COUNT_LOW,
    input  wire logic             COUNT_STEP,
    output logic                  MODULE_PIN_O,
    output logic                  MODULE_PIN_OE,
    output logic                  MODULE_EVENT_FLAG
);
    import ccp_pkg::*;

    // Register state
    ccp_byte_t   cfg_q;
    logic        flag_q;
    logic        flag_d;
    logic        pin_q;
    logic        pin_d;
    logic [31:0] rdata_q;
    ccp_byte_t   cmp_l_sh;
    ccp_byte_t   cmp_l_act;
    ccp_byte_t   cmp_h_sh;
    ccp_byte_t   cmp_h_act;
    ccp_mode_e   mode;

    // APB decode
    wire logic setup    = PSEL & ~PENABLE;
    wire logic access   = PSEL & PENABLE;
    wire logic hit_mode = PADDR == `CCP_ADDR_MODE;
    wire logic hit_lo   = PADDR == `CCP_ADDR_CMP_LOW;
    wire logic hit_hi   = PADDR == `CCP_ADDR_CMP_HIGH;
    wire logic hit_stat = PADDR == `CCP_ADDR_STATUS;
    wire logic mapped   = hit_mode | hit_lo | hit_hi | hit_stat;
    wire logic wr_en    = access & PWRITE & mapped;
    wire logic wr_mode  = wr_en & hit_mode;
    wire logic wr_lo    = wr_en & hit_lo;
    wire logic wr_hi    = wr_en & hit_hi;
    wire logic wr_stat  = wr_en & hit_stat;

    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~mapped;
    assign PRDATA  = rdata_q;

    // Mode bits
    wire logic b_of   = cfg_q[`CCP_BIT_OFS];
    wire logic b_cen  = cfg_q[`CCP_BIT_CMP_EN];
    wire logic b_rise = cfg_q[`CCP_BIT_RISE];
    wire logic b_fall = cfg_q[`CCP_BIT_FALL];
    wire logic b_mch  = cfg_q[`CCP_BIT_MATCH];
    wire logic b_tgl  = cfg_q[`CCP_BIT_TOGGLE];
    wire logic b_pwm  = cfg_q[`CCP_BIT_PWM];
    wire logic b_ie   = cfg_q[`CCP_BIT_IE];

    // Bit pattern of 16-bit compare with comparator enable left out
    wire logic cmp_shape = ~b_rise & ~b_fall & ~b_pwm;
    wire logic cfg_zero  = cfg_q == `CCP_RST_MODE;

    always_comb
    begin
        if (b_cen & b_pwm & b_rise & ~b_fall)
            mode = CCP_PWM16;
        else if (b_cen & b_pwm & ~b_rise & b_fall)
            mode = CCP_WIN;
        else if (b_cen & cmp_shape)
            mode = CCP_CMP16;
        else if (~b_cen & ~b_rise & ~b_fall & ~b_pwm)
            mode = CCP_NOP;
        else
            mode = CCP_OTHER;
    end

    // Comparator enable handling by hardware on compare byte writes
    wire logic hw_cen_set = wr_hi & cmp_shape & ~cfg_zero;
    wire logic hw_cen_clr = wr_lo & (mode == CCP_CMP16);

    ccp_byte_t cfg_d;
    always_comb
    begin
        cfg_d = cfg_q;
        if (wr_mode)
            cfg_d = PWDATA[7:0];
        else if (hw_cen_set)
            cfg_d[`CCP_BIT_CMP_EN] = 1'b1;
        else if (hw_cen_clr)
            cfg_d[`CCP_BIT_CMP_EN] = 1'b0;
    end

    // Count and compare paths
    ccp_cmp_if cif ();
    assign cif.count = {MAIN_COUNT_HIGH, MAIN_COUNT_LOW};
    assign cif.cmp   = {cmp_h_act, cmp_l_act};

    ccp_cmp u_cmp
    (
        .c (cif.calc)
    );

    // Buffered compare reload at the wrap point of the running mode
    wire logic wrap16 = cif.count == 16'h0000;
    wire logic wrap8  = MAIN_COUNT_LOW == 8'h00;
    wire logic load_on_wrap =
        COUNT_STEP & ((mode == CCP_WIN) ? wrap8 : wrap16);
    wire logic idle_load = (mode == CCP_NOP) | (mode == CCP_OTHER);
    wire logic load_act  = load_on_wrap | idle_load;

    ccp_cbuf u_buf_lo
    (
        .clk      (CLK),
        .nrst     (NRST),
        .wr       (wr_lo),
        .wdata    (PWDATA[7:0]),
        .load     (load_act),
        .shadow_q (cmp_l_sh),
        .active_q (cmp_l_act)
    );

    ccp_cbuf u_buf_hi
    (
        .clk      (CLK),
        .nrst     (NRST),
        .wr       (wr_hi),
        .wdata    (PWDATA[7:0]),
        .load     (load_act),
        .shadow_q (cmp_h_sh),
        .active_q (cmp_h_act)
    );

    // Windowed output: open past low compare, shut past high compare
    wire logic window  = cif.lo_gt_l & ~cif.lo_gt_h;
    wire logic pin_w   = window ^ b_tgl;
    wire logic pin_p16 = b_tgl | cif.gt16;

    // Match action on the pin for 16-bit compare
    logic pin_c16;
    always_comb
    begin
        case ({b_of, b_tgl})
            2'b00:   pin_c16 = pin_q;
            2'b01:   pin_c16 = ~pin_q;
            2'b10:   pin_c16 = 1'b0;
            2'b11:   pin_c16 = 1'b1;
            default: pin_c16 = pin_q;
        endcase
    end

    always_comb
    begin
        pin_d = pin_q;
        if (COUNT_STEP)
        begin
            case (mode)
                CCP_PWM16: pin_d = pin_p16;
                CCP_WIN:   pin_d = pin_w;
                CCP_CMP16: pin_d = cif.eq16 ? pin_c16 : pin_q;
                CCP_NOP:   pin_d = pin_q;
                CCP_OTHER: pin_d = pin_q;
                default:   pin_d = pin_q;
            endcase
        end
        else if (mode == CCP_PWM16 && b_tgl)
            pin_d = 1'b1;
    end

    // Module events
    logic event_hit;
    always_comb
    begin
        case (mode)
            CCP_PWM16: event_hit = cif.eq16;
            CCP_WIN:   event_hit = cif.lo_eq_l
                                 | (b_mch & cif.lo_eq_h);
            CCP_CMP16: event_hit = cif.eq16;
            CCP_NOP:   event_hit = 1'b0;
            CCP_OTHER: event_hit = 1'b0;
            default:   event_hit = 1'b0;
        endcase
    end

    wire logic event_set = COUNT_STEP & event_hit & b_ie;
    wire logic flag_clr  = wr_stat & PWDATA[`CCP_BIT_FLAG];

    // Set beats a clear in the same cycle
    always_comb
    begin
        flag_d = flag_q;
        if (flag_clr)
            flag_d = 1'b0;
        if (event_set)
            flag_d = 1'b1;
    end

    // Read data captured in the setup cycle
    wire ccp_byte_t status_v =
        {6'h00, pin_q, flag_q};
    wire logic [31:0] rd_mux =
        hit_mode ? {24'h000000, cfg_q} :
        hit_lo   ? {24'h000000, cmp_l_sh} :
        hit_hi   ? {24'h000000, cmp_h_sh} :
        hit_stat ? {24'h000000, status_v} :
                   32'h00000000;

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cfg_q   <= `CCP_RST_MODE;
            flag_q  <= 1'b0;
            pin_q   <= `CCP_RST_PIN;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            cfg_q  <= cfg_d;
            flag_q <= flag_d;
            pin_q  <= pin_d;
            if (setup && !PWRITE)
                rdata_q <= rd_mux;
        end
    end

    assign MODULE_PIN_O      = pin_q;
    assign MODULE_PIN_OE     = (mode == CCP_PWM16) | (mode == CCP_WIN)
                             | (mode == CCP_CMP16);
    assign MODULE_EVENT_FLAG = flag_q;
endmodule

//--- shared/ccp_params.svh
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH

// APB byte addresses
`define CCP_ADDR_MODE        8'h00
`define CCP_ADDR_CMP_LOW     8'h04
`define CCP_ADDR_CMP_HIGH    8'h08
`define CCP_ADDR_STATUS      8'h0c

// Mode configuration field positions
`define CCP_BIT_OFS          7
`define CCP_BIT_CMP_EN       6
`define CCP_BIT_RISE         5
`define CCP_BIT_FALL         4
`define CCP_BIT_MATCH        3
`define CCP_BIT_TOGGLE       2
`define CCP_BIT_PWM          1
`define CCP_BIT_IE           0

// Status field positions
`define CCP_BIT_FLAG         0
`define CCP_BIT_PIN          1

// Reset values
`define CCP_RST_MODE         8'h00
`define CCP_RST_CMP          8'h00
`define CCP_RST_PIN          1'b0

`endif

//--- shared/ccp_pkg.sv
package ccp_pkg;

    typedef enum logic [4:0] {
        CCP_NOP   = 5'b00001,
        CCP_CMP16 = 5'b00010,
        CCP_PWM16 = 5'b00100,
        CCP_WIN   = 5'b01000,
        CCP_OTHER = 5'b10000
    } ccp_mode_e;

    typedef logic [7:0]  ccp_byte_t;
    typedef logic [15:0] ccp_word_t;

endpackage

//--- shared/ccp_cmp_if.sv
`timescale 1ns/1ps
interface ccp_cmp_if;
    import ccp_pkg::*;
    ccp_word_t count;
    ccp_word_t cmp;
    logic      gt16;
    logic      eq16;
    logic      lo_gt_l;
    logic      lo_eq_l;
    logic      lo_gt_h;
    logic      lo_eq_h;

    modport calc
    (
        input  count,
        input  cmp,
        output gt16,
        output eq16,
        output lo_gt_l,
        output lo_eq_l,
        output lo_gt_h,
        output lo_eq_h
    );

    modport user
    (
        output count,
        output cmp,
        input  gt16,
        input  eq16,
        input  lo_gt_l,
        input  lo_eq_l,
        input  lo_gt_h,
        input  lo_eq_h
    );
endinterface

//--- core/ccp_cbuf.sv
`timescale 1ns/1ps
`include "ccp_params.svh"
module ccp_cbuf
(
    input  wire logic            clk,
    input  wire logic            nrst,
    input  wire logic            wr,
    input  wire ccp_pkg::ccp_byte_t wdata,
    input  wire logic            load,
    output ccp_pkg::ccp_byte_t   shadow_q,
    output ccp_pkg::ccp_byte_t   active_q
);
    import ccp_pkg::*;

    // Shadow takes software writes, active feeds the comparator
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            shadow_q <= `CCP_RST_CMP;
            active_q <= `CCP_RST_CMP;
        end
        else
        begin
            if (wr)
                shadow_q <= wdata;
            if (load)
                active_q <= wr ? wdata : shadow_q;
        end
    end
endmodule

//--- core/ccp_cmp.sv
`timescale 1ns/1ps
module ccp_cmp
(
    ccp_cmp_if.calc c
);
    import ccp_pkg::*;

    wire ccp_byte_t lo    = c.count[7:0];
    wire ccp_byte_t cmp_l = c.cmp[7:0];
    wire ccp_byte_t cmp_h = c.cmp[15:8];

    assign c.gt16    = c.count > c.cmp;
    assign c.eq16    = c.count == c.cmp;
    assign c.lo_gt_l = lo > cmp_l;
    assign c.lo_eq_l = lo == cmp_l;
    assign c.lo_gt_h = lo > cmp_h;
    assign c.lo_eq_h = lo == cmp_h;
endmodule

//--- sim/ccp_checker.sv
`timescale 1ns/1ps
module ccp_checker
(
    input wire logic               CLK,
    input wire logic               NRST,
    input wire logic               PSEL,
    input wire logic               PENABLE,
    input wire logic               PWRITE,
    input wire logic [7:0]         PADDR,
    input wire logic [31:0]        PWDATA,
    input wire logic [31:0]        PRDATA,
    input wire logic               PREADY,
    input wire ccp_pkg::ccp_byte_t MAIN_COUNT_HIGH,
    input wire ccp_pkg::ccp_byte_t MAIN_COUNT_LOW,
    input wire logic               COUNT_STEP,
    input wire logic               MODULE_PIN_O,
    input wire logic               MODULE_PIN_OE,
    input wire logic               MODULE_EVENT_FLAG
);
    import ccp_pkg::*;
    logic [7:0] m_q, sl_q, sh_q, al_q, ah_q;
    wire wr = PSEL && PENABLE && PWRITE && PREADY;
    wire st = COUNT_STEP;
    wire tg = m_q[2];
    wire p16 = m_q[6] && m_q[5:4] == 2'b10 && m_q[1];
    wire wp = m_q[6] && m_q[5:4] == 2'b01 && m_q[1];
    wire c16 = m_q[6] && m_q[5:4] == 2'b00 && !m_q[1];
    wire act = p16 || wp || c16;
    wire [15:0] cnt = {MAIN_COUNT_HIGH, MAIN_COUNT_LOW};
    wire [7:0] lo = MAIN_COUNT_LOW;
    wire [15:0] ac = {ah_q, al_q};
    wire ld = !act || st && (wp ? lo == 8'h00 : cnt == 16'h0000);
    wire hit = wp ? lo == al_q || m_q[3] && lo == ah_q : cnt == ac;
    wire win = (lo > al_q && !(lo > ah_q)) ^ tg;
    wire m_set = wr && PADDR == 8'h08 && m_q[5:4] == 2'b00 && !m_q[1]
                 && m_q != 8'h00;
    wire m_clr = wr && PADDR == 8'h04 && c16;
    wire [7:0] nsl = (wr && PADDR == 8'h04) ? PWDATA[7:0] : sl_q;
    wire [7:0] nsh = (wr && PADDR == 8'h08) ? PWDATA[7:0] : sh_q;

    // Shadow of the mode and compare registers
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            {m_q, sl_q, sh_q, al_q, ah_q} <= 40'h0;
        else
        begin
            if (wr && PADDR == 8'h00)
                m_q <= PWDATA[7:0];
            else if (m_set)
                m_q[6] <= 1'b1;
            else if (m_clr)
                m_q[6] <= 1'b0;
            if (wr && PADDR == 8'h04)
                sl_q <= PWDATA[7:0];
            if (wr && PADDR == 8'h08)
                sh_q <= PWDATA[7:0];
            if (ld)
                {ah_q, al_q} <= {nsh, nsl};
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    AST_OE: assert property (MODULE_PIN_OE == act)
        else $error("pin enable wrong");
    AST_PWM: assert property (st && p16 && !tg |=>
        MODULE_PIN_O == $past(cnt > ac)) else $error("pwm16 pin wrong");
    AST_TOG16: assert property ((p16 && tg)[*2] |-> MODULE_PIN_O)
        else $error("pwm16 forced pin low");
    AST_WIN: assert property (st && wp |=> MODULE_PIN_O == $past(win))
        else $error("window pin wrong");
    AST_FLAG: assert property (st && m_q[0] && act && hit |=>
        MODULE_EVENT_FLAG) else $error("flag not set");
    AST_NOFLAG: assert property ($rose(MODULE_EVENT_FLAG) |->
        $past(st && m_q[0])) else $error("flag without event");
    AST_CMP_DRV: assert property (st && c16 && hit && m_q[7] |=>
        MODULE_PIN_O == $past(tg)) else $error("compare drive wrong");
    AST_CMP_TOG: assert property (st && c16 && hit && m_q[7:6] == 2'b01
        && tg |=> MODULE_PIN_O != $past(MODULE_PIN_O))
        else $error("compare toggle wrong");
    AST_MODE_RD: assert property (PSEL && !PENABLE && !PWRITE
        && PADDR == 8'h00 |=> PRDATA[7:0] == $past(m_q))
        else $error("mode readback wrong");

    cover property (st && p16 && hit);
    cover property (st && wp && m_q[3] && lo == ah_q);
    cover property (st && c16 && hit && tg);
endmodule

bind ccp_top ccp_checker u_chk
(
    .CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .MAIN_COUNT_HIGH, .MAIN_COUNT_LOW, .COUNT_STEP,
    .MODULE_PIN_O, .MODULE_PIN_OE, .MODULE_EVENT_FLAG
);

//--- sim/ccp_pin_model.sv
`timescale 1ns/1ps
module ccp_pin_model
(
    input wire logic clk,
    input wire logic drv,
    input wire logic oe,
    output logic     line
);
    logic last_q;
    always_ff @(posedge clk)
    begin
        if (oe)
            last_q <= drv;
    end
    // Released pin shows the inverse of the last driven level
    assign line = oe ? drv : ~last_q;
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ccp_pkg::*;
    logic        clk, nrst, psel, pen, pwr, stp, stp_d, p;
    logic        pready, pslverr, pin_o, pin_oe, flag, line;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] c;
    ccp_byte_t   cnt_hi, cnt_lo;
    logic [31:0] rq[$];
    logic        pq[$];
    logic        eq[$];
    int          n_mismatch, n_checks, seed, i, t;

    ccp_top dut
    (
        .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .MAIN_COUNT_HIGH(cnt_hi),
        .MAIN_COUNT_LOW(cnt_lo), .COUNT_STEP(stp), .MODULE_PIN_O(pin_o),
        .MODULE_PIN_OE(pin_oe), .MODULE_EVENT_FLAG(flag)
    );
    ccp_pin_model pin_m
    (
        .clk(clk), .drv(pin_o), .oe(pin_oe), .line(line)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic conclude;
        if (n_mismatch == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk_rd(input logic [31:0] e);
        n_checks++;
        if (prdata !== e)
        begin
            n_mismatch++;
            $display("Error prdata exp %h got %h", e, prdata);
        end
    endtask

    task automatic chk_pin(input logic e);
        n_checks++;
        if (line !== e)
        begin
            n_mismatch++;
            $display("Error pin exp %b got %b", e, line);
        end
    endtask

    task automatic chk_err(input logic e);
        n_checks++;
        if (pslverr !== e)
        begin
            n_mismatch++;
            $display("Error pslverr exp %b got %b", e, pslverr);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        eq.push_back(!(a inside {8'h00, 8'h04, 8'h08, 8'h0c}));
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic step(input logic [15:0] v, input logic e);
        @(posedge clk);
        {cnt_hi, cnt_lo} <= v;
        stp      <= 1'b1;
        pq.push_back(e);
    endtask

    task automatic idle;
        @(posedge clk);
        stp <= 1'b0;
    endtask

    always @(posedge clk)
    begin
        if (psel === 1'b1 && pen === 1'b1 && pready === 1'b1 && !pwr)
            chk_rd(rq.pop_front());
        if (psel === 1'b1 && pen === 1'b1 && pready === 1'b1)
            chk_err(eq.pop_front());
        if (stp_d === 1'b1)
            chk_pin(pq.pop_front());
        stp_d <= stp;
    end

    initial
    begin
        #20000;
        n_mismatch++;
        conclude;
    end

    initial
    begin
        {nrst, psel, pen, pwr, stp} = 5'h0;
        {paddr, pwdata, cnt_hi, cnt_lo} = 56'h0;
        n_mismatch = 0;
        n_checks = 0;
        seed = 92;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 5; i++)
            rd(8'(i * 4), 32'h0);
        wr(8'h10, 32'hff);
        rd(8'h10, 32'h0);
        wr(8'h04, 32'h34);
        wr(8'h08, 32'h12);
        rd(8'h00, 32'h0);
        wr(8'h00, 32'h63);
        for (i = 0; i < 40; i++)
        begin
            c = (i < 2) ? 16'h1234 + 16'(i) : 16'($random(seed));
            step(c, c > 16'h1234);
        end
        idle;
        wr(8'h0c, 32'h1);
        step(16'h1234, 1'b0);
        idle;
        rd(8'h0c, 32'h1);
        wr(8'h00, 32'h67);
        step(16'h0001, 1'b1);
        step(16'h0000, 1'b1);
        idle;
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h20);
        wr(8'h08, 32'h80);
        for (t = 0; t < 2; t++)
        begin
            wr(8'h00, {24'h0, 5'h0a, t[0], 2'h3});
            for (i = 0; i < 256; i++)
            begin
                c = {8'($random(seed)), 8'(i)};
                step(c, (i > 32 && i <= 128) ^ t[0]);
            end
            idle;
        end
        wr(8'h0c, 32'h1);
        step(16'h0080, 1'b0);
        idle;
        rd(8'h0c, 32'h0);
        wr(8'h00, 32'h5f);
        step(16'h0080, 1'b0);
        idle;
        rd(8'h0c, 32'h1);
        wr(8'h00, 32'h05);
        wr(8'h08, 32'h00);
        rd(8'h00, 32'h45);
        wr(8'h04, 32'h05);
        rd(8'h00, 32'h05);
        for (i = 3; i >= 0; i--)
        begin
            wr(8'h00, {24'h0, i[1], 4'h8, i[0], 2'h1});
            p = (i == 3) ? 1'b1 : (i == 2) ? 1'b0 : (i == 1) ? !p : p;
            step(16'h0005, p);
            step(16'h0006, p);
            idle;
        end
        repeat (2) @(posedge clk);
        conclude;
    end
endmodule
